/* bench/mcs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_assertions (
   input wire sys_clk,
   input wire rst,
   input wire sw_reset,
   input wire cmd_start,
   input wire [31:0] cmd_word,
   input wire [13:0] mcast_list_byte_count,
   input wire cu_abort,
   input wire mem_rd_req,
   input wire [13:0] mem_rd_offset,
   input wire mem_rd_ack,
   input wire cmd_busy,
   input wire cmd_complete,
   input wire cmd_ok,
   input wire cmd_aborted,
   input wire cmd_done,
   input wire rx_da_valid,
   input wire [47:0] rx_da,
   input wire rx_result_valid,
   input wire rx_mcast_accept,
   input wire accept_all_mcast,
   input wire full_duplex_enable,
   input wire crc_in_mem_disable,
   input wire auto_retransmit,
   input wire [3:0] fifo_threshold,
   input wire [3:0] retry_limit,
   input wire [10:0] slot_time
);
   wire start_ok = cmd_start && cmd_word[18:16] == 3'h3 && !cmd_busy;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_rst_defaults:
   assert property ($fell(rst) |-> !full_duplex_enable && crc_in_mem_disable
      && fifo_threshold == 4'h8 && retry_limit == 4'hF && slot_time == 11'h200)
      else $error("configuration defaults wrong after reset");
   a_swrst_reload:
   assert property (sw_reset |-> ##2 !full_duplex_enable && auto_retransmit)
      else $error("software reset did not reload defaults");
   a_setup_busy:
   assert property (start_ok |=> cmd_busy) else $error("setup command not taken");
   a_bad_code:
   assert property (cmd_start && cmd_word[18:16] != 3'h3 && !cmd_busy |=> !cmd_busy)
      else $error("other command code taken");
   a_zero_done:
   assert property (start_ok && mcast_list_byte_count == 14'h0 |-> ##4
      cmd_done && cmd_complete && cmd_ok && !cmd_busy ##1 !cmd_done)
      else $error("empty list completion wrong");
   a_abort_flag:
   assert property (cmd_busy && cu_abort |-> ##[1:4] cmd_aborted && !cmd_ok && !mem_rd_req)
      else $error("abort not reported");
   a_req_hold:
   assert property (mem_rd_req && !mem_rd_ack && !cu_abort |=>
      mem_rd_req && $stable(mem_rd_offset))
      else $error("read request dropped early");
   a_rx_answer:
   assert property (rx_da_valid |=> rx_result_valid ##1 !rx_result_valid)
      else $error("receive result pulse wrong");
   a_all_mcast:
   assert property (rx_da_valid && rx_da[0] && accept_all_mcast |=> rx_mcast_accept)
      else $error("multicast not accepted in accept-all mode");
endmodule
bind mcs_mac_cfg mcs_assertions u_chk (.*);
`default_nettype wire

/* bench/mcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_host_model (
   input wire sys_clk,
   input wire rst,
   input wire [1:0] wait_cycles,
   input wire mem_rd_req,
   input wire [13:0] mem_rd_offset,
   output logic mem_rd_ack,
   output logic [7:0] mem_rd_data
);
   logic [7:0] mem [0:63];
   int n_reads = 0;
   int waited = 0;
   always @(negedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_rd_ack <= 1'b0;
         mem_rd_data <= 8'hA5;
      end else if (mem_rd_req && !mem_rd_ack && waited >= wait_cycles) begin
         mem_rd_ack <= 1'b1;
         mem_rd_data <= mem[mem_rd_offset[5:0]];
         waited <= 0;
      end else begin
         mem_rd_ack <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         waited <= (mem_rd_req && !mem_rd_ack) ? waited + 1 : 0;
      end
   end
   always @(posedge sys_clk) begin
      if (mem_rd_req && mem_rd_ack) begin
         n_reads <= n_reads + 1;
      end
   end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = '0, rst = '1, sw_reset = '0, cfg_wr = '0, cmd_start = '0, cu_abort = '0;
   logic rx_da_valid = '0, mem_rd_req, mem_rd_ack, cmd_busy, cmd_complete, cmd_ok;
   logic cmd_aborted, cmd_done, rx_result_valid, rx_mcast_accept, rx_ia_hash_hit;
   logic full_duplex_enable, backoff_disable, multi_individual_addr_enable, accept_all_mcast;
   logic crc_in_mem_disable, auto_retransmit, no_crc_insertion, rbd_prefetch;
   logic [3:0] cfg_index = '0, fifo_threshold, retry_limit;
   logic [7:0] cfg_data = '0, mem_rd_data, interframe_spacing, min_frame_length;
   logic [31:0] cmd_word = '0;
   logic [13:0] mcast_list_byte_count = '0, mem_rd_offset;
   logic [47:0] rx_da = '0;
   logic [2:0] station_address_length;
   logic [10:0] slot_time;
   logic [1:0] wait_cycles = '0;
   int n_mismatch = 0, n_tests = 0;
   localparam logic [47:0] ADDR_A = 48'h665544332201;
   localparam logic [47:0] ADDR_B = 48'h0A0B0C0D0E03;
   localparam logic [47:0] ADDR_I = 48'h0A0908070600;
   mcs_mac_cfg u_dut (.*);
   mcs_host_model u_host (.*);
   always #12.5 sys_clk = ~sys_clk;
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cfg(input logic [3:0] i, input logic [7:0] d);
      @(negedge sys_clk) {cfg_wr, cfg_index, cfg_data} = {1'b1, i, d};
      @(negedge sys_clk) cfg_wr = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic load(input logic [47:0] a, input int k);
      for (int i = 0; i < 6; i++)
         u_host.mem[k * 6 + i] = a[8 * i +: 8];
   endtask
   task automatic mc(input logic [2:0] code, input logic [13:0] n, input int ab);
      u_host.n_reads = 0;
      @(negedge sys_clk) {cmd_start, mcast_list_byte_count} = {1'b1, n};
      cmd_word = {13'h0, code, 16'h0}; // and
      @(negedge sys_clk) cmd_start = 1'b0;
      if (ab > 0) begin
         repeat (ab) @(negedge sys_clk);
         cu_abort = 1'b1;
         @(negedge sys_clk) cu_abort = 1'b0;
      end
      for (int k = 0; k < 500 && cmd_busy !== 1'b0; k++)
         @(negedge sys_clk);
      chk(cmd_busy, 1'b0);
   endtask
   task automatic rx(input logic [47:0] a, input logic ex);
      @(negedge sys_clk) {rx_da_valid, rx_da} = {1'b1, a};
      @(negedge sys_clk) rx_da_valid = 1'b0;
      chk(rx_result_valid, 1'b1);
      chk(rx_mcast_accept, ex);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      wrap_up;
   end
   initial begin
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      chk({full_duplex_enable, crc_in_mem_disable, auto_retransmit, no_crc_insertion,
         rbd_prefetch}, 5'h0C);
      chk({fifo_threshold, retry_limit, interframe_spacing, slot_time, min_frame_length},
         {4'h8, 4'hF, 8'h60, 11'h200, 8'h40});
      chk({accept_all_mcast, backoff_disable, multi_individual_addr_enable,
         station_address_length}, 6'h06);
      $display("test defaults done");
      cfg(4'hC, 8'h40);
      chk(full_duplex_enable, 1'b1);
      cfg(4'hB, 8'hDF);
      rx(48'h112233445507, 1'b1);
      @(negedge sys_clk) sw_reset = 1'b1;
      @(negedge sys_clk) sw_reset = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({full_duplex_enable, accept_all_mcast}, 2'h0);
      $display("test config done");
      load(ADDR_A, 0);
      load(ADDR_B, 1);
      load(48'hFFFFFF, 2);
      wait_cycles = 2'h1;
      mc(3'h3, 14'hF, 0);
      chk(u_host.n_reads, 12);
      chk({cmd_complete, cmd_ok, cmd_aborted, cmd_busy}, 4'hC);
      rx(ADDR_A, 1'b1);
      rx(ADDR_B, 1'b1);
      mc(3'h3, 14'h0, 0);
      chk(u_host.n_reads, 0);
      rx(ADDR_A, 1'b0);
      mc(3'h4, 14'h6, 0);
      chk(u_host.n_reads, 0);
      $display("test setup done");
      wait_cycles = 2'h3;
      mc(3'h3, 14'hC, 4);
      chk({cmd_complete, cmd_ok, cmd_aborted, cmd_busy}, 4'hA);
      $display("test abort done");
      cfg(4'hD, 8'h7F);
      load(ADDR_I, 0);
      wait_cycles = 2'h0;
      mc(3'h3, 14'h6, 0);
      rx(ADDR_I, 1'b0);
      chk(rx_ia_hash_hit, 1'b1);
      $display("test individual hash done");
      wrap_up;
   end
endmodule
`default_nettype wire

/* hw/mcs_defs.vh */
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

// Configuration byte defaults loaded by any reset.
`define MCS_CFG_BYTES 14
`define MCS_CFG0_RST 8'h0E
`define MCS_CFG1_RST 8'h08
`define MCS_CFG2_RST 8'h00
`define MCS_CFG3_RST 8'h06
`define MCS_CFG4_RST 8'hF0
`define MCS_CFG5_RST 8'h60
`define MCS_CFG6_RST 8'h00
`define MCS_CFG7_RST 8'h02
`define MCS_CFG8_RST 8'h40
`define MCS_CFG9_RST 8'h00
`define MCS_CFG10_RST 8'h00
`define MCS_CFG11_RST 8'hFF
`define MCS_CFG12_RST 8'h00
`define MCS_CFG13_RST 8'h3F

// Field positions inside the configuration bytes.
`define MCS_FIFO_THR_BYTE 1
`define MCS_PREFETCH_BYTE 2
`define MCS_PREFETCH_BIT 7
`define MCS_STATION_ADDRESS_LENGTH_BYTE 3
`define MCS_NO_CRC_BIT 3
`define MCS_RETRY_BYTE 4
`define MCS_IFS_BYTE 5
`define MCS_SLOT_LO_BYTE 6
`define MCS_SLOT_HI_BYTE 7
`define MCS_MIN_FRAME_BYTE 8
`define MCS_RXOPT_BYTE 11
`define MCS_CRC_IN_MEM_BIT 2
`define MCS_AUTO_RETX_BIT 3
`define MCS_ACCEPT_ALL_MCAST_BIT 5
`define MCS_FDX_BYTE 12
`define MCS_FDX_BIT 6
`define MCS_BOF_BYTE 13
`define MCS_BACKOFF_DISABLE_BIT 7
`define MCS_MULTI_INDIVIDUAL_ADDR_ENABLE_BIT 6

// Command word decoding.
`define MCS_CMD_LSB 16
`define MCS_CMD_MC_SETUP 3'h3

`endif

/* hw/mcs_mac_cfg.v */
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.vh"

// Behaviour
// - Any reset loads every configuration default.
// - Full duplex defaults off; byte 12 bit 6.
// - CRC-in-memory defaults 1, CRC not stored.
// - FIFO threshold defaults to 8.
// - Retry count defaults to 15.
// - Auto retransmit defaults enabled.
// - Defaults: 96 IFS, 512 slot, 64 frame.
// - No-CRC-insertion defaults 0, CRC appended.
// - Descriptor prefetch defaults disabled.
// - Setup clears filter, then rebuilds it.
// - Hash filter may pass unlisted multicast.
// - Command code 3h in bits 16-18.
// - Read only whole addresses of the 14-bit count.
// - Count rounds down to address-length multiple.
// - Zero count leaves hash table cleared.
// - Addresses packed back to back.
// - Multi-IA uses setup for individual hashes.
// - Abort in fetch or hash sets aborted bit, else 0.
// - Byte 11 bit 5 clear accepts all multicast.
module mcs_mac_cfg (
   input wire sys_clk,
   input wire rst,
   input wire sw_reset,
   input wire cfg_wr,
   input wire [3:0] cfg_index,
   input wire [7:0] cfg_data,
   input wire cmd_start,
   input wire [31:0] cmd_word,
   input wire [13:0] mcast_list_byte_count,
   input wire cu_abort,
   output reg mem_rd_req,
   output reg [13:0] mem_rd_offset,
   input wire mem_rd_ack,
   input wire [7:0] mem_rd_data,
   output reg cmd_busy,
   output reg cmd_complete,
   output reg cmd_ok,
   output reg cmd_aborted,
   output reg cmd_done,
   input wire rx_da_valid,
   input wire [47:0] rx_da,
   output reg rx_result_valid,
   output reg rx_mcast_accept,
   output reg rx_ia_hash_hit,
   output reg full_duplex_enable,
   output reg backoff_disable,
   output reg multi_individual_addr_enable,
   output reg accept_all_mcast,
   output reg crc_in_mem_disable,
   output reg auto_retransmit,
   output reg no_crc_insertion,
   output reg rbd_prefetch,
   output reg [3:0] fifo_threshold,
   output reg [3:0] retry_limit,
   output reg [2:0] station_address_length,
   output reg [7:0] interframe_spacing,
   output reg [10:0] slot_time,
   output reg [7:0] min_frame_length
);

   localparam ST_IDLE = 3'd0;
   localparam ST_CLEAR = 3'd1;
   localparam ST_FETCH = 3'd2;
   localparam ST_HASH = 3'd3;
   localparam ST_DONE = 3'd4;

   reg [7:0] cfg [0:`MCS_CFG_BYTES-1];
   reg [63:0] hash_table;
   reg [2:0] state;
   reg [13:0] remaining;
   reg [2:0] grp_pos;
   reg [2:0] grp_len;
   reg [47:0] addr_buf;
   reg [2:0] next_state;
   reg cu_abort_seen;
   integer i;

   // Six-bit hash index from the CRC-32 of a station address.
   function [5:0] mcs_hash;
      input [47:0] addr;
      reg [31:0] crc;
      integer k;
      begin
         crc = 32'hFFFFFFFF;
         for (k = 0; k < 48; k = k + 1) begin
            if (crc[31] ^ addr[k]) begin
               crc = {crc[30:0], 1'b0} ^ 32'h04C11DB7;
            end else begin
               crc = {crc[30:0], 1'b0};
            end
         end
         mcs_hash = crc[31:26];
      end
   endfunction

   // Reset value of one configuration byte.
   function [7:0] mcs_cfg_default;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: mcs_cfg_default = `MCS_CFG0_RST;
            4'h1: mcs_cfg_default = `MCS_CFG1_RST;
            4'h2: mcs_cfg_default = `MCS_CFG2_RST;
            4'h3: mcs_cfg_default = `MCS_CFG3_RST;
            4'h4: mcs_cfg_default = `MCS_CFG4_RST;
            4'h5: mcs_cfg_default = `MCS_CFG5_RST;
            4'h6: mcs_cfg_default = `MCS_CFG6_RST;
            4'h7: mcs_cfg_default = `MCS_CFG7_RST;
            4'h8: mcs_cfg_default = `MCS_CFG8_RST;
            4'h9: mcs_cfg_default = `MCS_CFG9_RST;
            4'hA: mcs_cfg_default = `MCS_CFG10_RST;
            4'hB: mcs_cfg_default = `MCS_CFG11_RST;
            4'hC: mcs_cfg_default = `MCS_CFG12_RST;
            4'hD: mcs_cfg_default = `MCS_CFG13_RST;
            default: mcs_cfg_default = 8'h00;
         endcase
      end
   endfunction

   // Configuration store; a software reset reloads the defaults.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg[0] <= `MCS_CFG0_RST;
         cfg[1] <= `MCS_CFG1_RST;
         cfg[2] <= `MCS_CFG2_RST;
         cfg[3] <= `MCS_CFG3_RST;
         cfg[4] <= `MCS_CFG4_RST;
         cfg[5] <= `MCS_CFG5_RST;
         cfg[6] <= `MCS_CFG6_RST;
         cfg[7] <= `MCS_CFG7_RST;
         cfg[8] <= `MCS_CFG8_RST;
         cfg[9] <= `MCS_CFG9_RST;
         cfg[10] <= `MCS_CFG10_RST;
         cfg[11] <= `MCS_CFG11_RST; // and
         cfg[12] <= `MCS_CFG12_RST;
         cfg[13] <= `MCS_CFG13_RST;
      end else if (sw_reset) begin
         for (i = 0; i < `MCS_CFG_BYTES; i = i + 1) begin
            cfg[i] <= mcs_cfg_default(i[3:0]);
         end
      end else if (cfg_wr && cfg_index < `MCS_CFG_BYTES && !cmd_busy) begin
         cfg[cfg_index] <= cfg_data;
      end
   end

   // Configuration outputs, registered from the store.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         full_duplex_enable <= 1'b0;
         backoff_disable <= 1'b0;
         multi_individual_addr_enable <= 1'b0;
         accept_all_mcast <= 1'b0;
         crc_in_mem_disable <= 1'b1;
         auto_retransmit <= 1'b1;
         no_crc_insertion <= 1'b0;
         rbd_prefetch <= 1'b0;
         fifo_threshold <= 4'h8;
         retry_limit <= 4'hF;
         station_address_length <= 3'h6;
         interframe_spacing <= 8'h60;
         slot_time <= 11'h200;
         min_frame_length <= 8'h40;
      end else begin
         full_duplex_enable <= cfg[`MCS_FDX_BYTE][`MCS_FDX_BIT];
         backoff_disable <= cfg[`MCS_BOF_BYTE][`MCS_BACKOFF_DISABLE_BIT];
         multi_individual_addr_enable <= cfg[`MCS_BOF_BYTE][`MCS_MULTI_INDIVIDUAL_ADDR_ENABLE_BIT];
         accept_all_mcast <= ~cfg[`MCS_RXOPT_BYTE][`MCS_ACCEPT_ALL_MCAST_BIT];
         crc_in_mem_disable <= cfg[`MCS_RXOPT_BYTE][`MCS_CRC_IN_MEM_BIT];
         auto_retransmit <= cfg[`MCS_RXOPT_BYTE][`MCS_AUTO_RETX_BIT];
         no_crc_insertion <= cfg[`MCS_STATION_ADDRESS_LENGTH_BYTE][`MCS_NO_CRC_BIT];
         rbd_prefetch <= cfg[`MCS_PREFETCH_BYTE][`MCS_PREFETCH_BIT];
         fifo_threshold <= cfg[`MCS_FIFO_THR_BYTE][3:0];
         retry_limit <= cfg[`MCS_RETRY_BYTE][7:4];
         station_address_length <= cfg[`MCS_STATION_ADDRESS_LENGTH_BYTE][2:0];
         interframe_spacing <= cfg[`MCS_IFS_BYTE];
         slot_time <= {cfg[`MCS_SLOT_HI_BYTE][2:0], cfg[`MCS_SLOT_LO_BYTE]};
         min_frame_length <= cfg[`MCS_MIN_FRAME_BYTE];
      end
   end

   // Sequencer state selection.
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cmd_start && cmd_word[`MCS_CMD_LSB+2:`MCS_CMD_LSB] == `MCS_CMD_MC_SETUP) begin
               next_state = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            next_state = ST_FETCH;
         end
         ST_FETCH: begin
            if (cu_abort) begin
               next_state = ST_DONE;
            end else if (grp_pos == 3'd0 && !mem_rd_req &&
                         (grp_len == 3'd0 || remaining < {11'h000, grp_len})) begin
               next_state = ST_DONE; // and
            end else if (mem_rd_req && mem_rd_ack && grp_pos == grp_len - 3'd1) begin
               next_state = ST_HASH;
            end
         end
         ST_HASH: begin
            next_state = cu_abort ? ST_DONE : ST_FETCH;
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Multicast setup sequencer with its list fetch and status.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         hash_table <= 64'h0000000000000000;
         remaining <= 14'h0000;
         grp_pos <= 3'd0;
         grp_len <= 3'd0;
         addr_buf <= 48'h000000000000;
         mem_rd_req <= 1'b0;
         mem_rd_offset <= 14'h0000;
         cmd_busy <= 1'b0;
         cmd_complete <= 1'b0;
         cmd_ok <= 1'b0;
         cmd_aborted <= 1'b0;
         cmd_done <= 1'b0;
      end else begin
         state <= next_state;
         cmd_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (next_state == ST_CLEAR) begin
                  cmd_busy <= 1'b1;
                  cmd_complete <= 1'b0;
                  cmd_ok <= 1'b0;
                  cmd_aborted <= 1'b0;
                  remaining <= mcast_list_byte_count;
                  grp_len <= station_address_length;
                  mem_rd_offset <= 14'h0000;
               end
            end
            ST_CLEAR: begin
               hash_table <= 64'h0000000000000000;
               grp_pos <= 3'd0;
               addr_buf <= 48'h000000000000;
            end
            ST_FETCH: begin
               if (cu_abort) begin
                  mem_rd_req <= 1'b0;
               end else if (mem_rd_req && mem_rd_ack) begin
                  // Bytes arrive back to back; no gap between addresses.
                  addr_buf[grp_pos*8 +: 8] <= mem_rd_data;
                  mem_rd_req <= 1'b0;
                  mem_rd_offset <= mem_rd_offset + 14'h0001;
                  remaining <= remaining - 14'h0001;
                  grp_pos <= grp_pos + 3'd1;
               end else if (!mem_rd_req && next_state == ST_FETCH) begin
                  mem_rd_req <= 1'b1;
               end
            end
            ST_HASH: begin
               // Multicast and individual entries share one table.
               hash_table[mcs_hash(addr_buf)] <= 1'b1; // and
               grp_pos <= 3'd0;
               addr_buf <= 48'h000000000000;
            end
            ST_DONE: begin
               cmd_busy <= 1'b0;
               cmd_complete <= 1'b1;
               cmd_ok <= ~cu_abort_seen;
               cmd_aborted <= cu_abort_seen;
               cmd_done <= 1'b1;
            end
            default: begin
               cmd_busy <= 1'b0;
            end
         endcase
      end
   end

   // Remembers an abort taken in fetch or hash until it is reported.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cu_abort_seen <= 1'b0;
      end else if (state == ST_IDLE) begin
         cu_abort_seen <= 1'b0;
      end else if (cu_abort && (state == ST_FETCH || state == ST_HASH)) begin
         cu_abort_seen <= 1'b1;
      end
   end

   // Receive destination filtering.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_result_valid <= 1'b0;
         rx_mcast_accept <= 1'b0;
         rx_ia_hash_hit <= 1'b0;
      end else begin
         rx_result_valid <= rx_da_valid;
         if (rx_da_valid) begin
            rx_mcast_accept <= rx_da[0] &&
               (accept_all_mcast || hash_table[mcs_hash(rx_da)]); // and
            rx_ia_hash_hit <= !rx_da[0] && multi_individual_addr_enable &&
               hash_table[mcs_hash(rx_da)];
         end
      end
   end

endmodule
`default_nettype wire
